// File: core/pvp_core.sv
// Parallel video port: general-purpose and embedded-code video modes.
// Registers over AHB-Lite; the port clock is sampled by the system clock.
`timescale 1ns/100ps
module pvp_core
    import pvp_pkg::*;
#(
    parameter int DW = 16,
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Port pins
    input wire logic port_clock_i,
    input wire logic [2:0] frame_sync_i,
    output logic [2:0] frame_sync_o,
    output logic [2:0] frame_sync_oe_o,
    input wire logic [DW-1:0] data_i,
    output logic [DW-1:0] data_o,
    output logic data_oe_o
);

    logic [31:0] ctrl_q;
    logic [CW-1:0] delay_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] line_q;
    logic [CW-1:0] frame_q;
    logic [7:0] addr_q;
    logic wr_q;
    logic rd_q;
    logic [31:0] rdata;
    logic pclk_s;
    logic pclk_prev_q;
    logic [2:0] fs_s;
    logic fs1_prev_q;
    logic [DW-1:0] din_s;
    logic pe;
    pvp_state_t st_q;
    logic [CW-1:0] dcnt_q;
    logic [CW-1:0] scnt_q;
    logic [CW-1:0] col_q;
    logic [CW-1:0] row_q;
    logic [2:0] fs_q;
    logic [DW-1:0] rx_q;
    logic rxv_q;
    logic ovf_q;
    logic unf_q;
    logic [DW-1:0] tx_q;
    logic txf_q;
    logic [1:0] pre_q;
    logic fld_q;
    logic vb_q;
    logic synced_q;
    logic act_q;
    logic [CW-1:0] lines_q;
    logic [DW-1:0] dd_q [3];
    logic [2:0] dv_q;

    // Control decode
    logic en;
    logic fam;
    logic [1:0] sub;
    logic [4:0] wid;
    logic [DW-1:0] wmask;
    logic gp_out;
    logic vid_rx;
    logic vid_tx;
    logic trig;
    logic line_start;
    logic gp_take;
    logic vid_take;
    logic take;
    logic send;
    logic rd_data;
    logic wr_status;
    logic [7:0] w8;
    logic code;
    logic clr;
    logic win;
    logic [7:0] xy;

    assign en = ctrl_q[PVP_CTRL_EN];
    assign fam = ctrl_q[PVP_CTRL_FAM];
    assign sub = ctrl_q[PVP_CTRL_SUB +: 2];
    assign wid = ctrl_q[PVP_CTRL_WID +: 5];
    assign wmask = DW'(pvp_wmask(wid));
    assign gp_out = !fam && sub == PVP_SUB_OUT;
    assign vid_rx = en && fam && !ctrl_q[PVP_CTRL_DIR];
    assign vid_tx = en && fam && ctrl_q[PVP_CTRL_DIR];
    assign pe = pclk_s && !pclk_prev_q;

    // Pins pass four flops, three stages and the filter, before any core logic looks at them
    pvp_sync #(
        .W(DW + 4)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({port_clock_i, frame_sync_i, data_i}),
        .stable_o({pclk_s, fs_s, din_s})
    );

    // AHB-Lite address phase capture; reads take one wait state
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h0000_0000;
        end
        else
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout_o <= 1'b1;
            if (rd_q)
            begin
                hrdata_o <= rdata;
            end
            if (hready_i && hsel_i && htrans_i[1])
            begin
                addr_q <= haddr_i[7:0];
                wr_q <= hwrite_i;
                rd_q <= !hwrite_i;
                hreadyout_o <= hwrite_i;
            end
        end
    end

    assign rd_data = rd_q && addr_q == PVP_OFS_DATA;
    assign wr_status = wr_q && addr_q == PVP_OFS_STATUS;

    // Read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (addr_q)
            PVP_OFS_CTRL: rdata = ctrl_q;
            PVP_OFS_DELAY: rdata[CW-1:0] = delay_q;
            PVP_OFS_COUNT: rdata[CW-1:0] = count_q;
            PVP_OFS_LINE: rdata[CW-1:0] = line_q;
            PVP_OFS_FRAME: rdata[CW-1:0] = frame_q;
            PVP_OFS_DATA: rdata[DW-1:0] = rx_q;
            PVP_OFS_STATUS:
            begin
                rdata[PVP_ST_RXV] = rxv_q;
                rdata[PVP_ST_TXE] = !txf_q;
                rdata[PVP_ST_OVF] = ovf_q;
                rdata[PVP_ST_UNF] = unf_q;
                rdata[PVP_ST_SYNC] = synced_q;
                rdata[PVP_ST_BUSY] = st_q == PVP_DELAY || st_q == PVP_XFER || act_q;
                rdata[PVP_ST_FIELD] = fld_q;
                rdata[PVP_ST_VBL] = vb_q;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Configuration registers, written in the data phase
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= PVP_CTRL_RST;
            delay_q <= CW'(PVP_DELAY_RST);
            count_q <= CW'(PVP_COUNT_RST);
            line_q <= CW'(PVP_LINE_RST);
            frame_q <= CW'(PVP_FRAME_RST);
        end
        else if (wr_q)
        begin
            case (addr_q)
                PVP_OFS_CTRL: ctrl_q <= hwdata_i;
                PVP_OFS_DELAY: delay_q <= hwdata_i[CW-1:0];
                PVP_OFS_COUNT: count_q <= hwdata_i[CW-1:0];
                PVP_OFS_LINE: line_q <= hwdata_i[CW-1:0];
                PVP_OFS_FRAME: frame_q <= hwdata_i[CW-1:0];
                default: ;
            endcase
        end
    end

    // Port clock and frame sync one edge history
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pclk_prev_q <= 1'b0;
            fs1_prev_q <= 1'b0;
        end
        else
        begin
            pclk_prev_q <= pclk_s;
            if (pe)
            begin
                fs1_prev_q <= fs_s[0];
            end
        end
    end

    // Line and frame counters that time the generated syncs
    assign line_start = pe && col_q == '0;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !en || fam)
        begin
            col_q <= '0;
            row_q <= '0;
        end
        else if (pe)
        begin
            col_q <= col_q + CW'(1);
            if (col_q + CW'(1) >= line_q)
            begin
                col_q <= '0;
                row_q <= (row_q + CW'(1) >= frame_q) ? '0 : row_q + CW'(1);
            end
        end
    end

    // Generated syncs: one is line sync, two is frame sync, three marks data
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            fs_q <= 3'h0;
        end
        else if (pe)
        begin
            fs_q[0] <= col_q == '0;
            fs_q[1] <= col_q == '0 && row_q == '0;
            fs_q[2] <= st_q == PVP_XFER;
        end
    end

    // Sync pin drivers follow the per-pin direction bits only in enabled general-purpose submodes other than input
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            frame_sync_o <= 3'h0;
            frame_sync_oe_o <= 3'h0;
            data_oe_o <= 1'b0;
        end
        else
        begin
            frame_sync_o <= fs_q;
            frame_sync_oe_o <= (en && !fam && sub != PVP_SUB_IN) ?
                ctrl_q[PVP_CTRL_FSO +: 3] : 3'h0;
            data_oe_o <= (en && gp_out) || vid_tx;
        end
    end

    // Trigger: external sync one in input mode, own line start otherwise
    assign trig = (!fam && sub == PVP_SUB_IN) ? (pe && fs_s[0] && !fs1_prev_q) : line_start;

    // Framing sequencer: wait for trigger, delay, move count samples
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !en || fam)
        begin
            st_q <= PVP_IDLE;
            dcnt_q <= '0;
            scnt_q <= '0;
        end
        else
        begin
            unique case (st_q)
                PVP_IDLE: st_q <= PVP_WAIT;
                PVP_WAIT:
                begin
                    if (trig && count_q != '0)
                    begin
                        dcnt_q <= delay_q;
                        scnt_q <= '0;
                        st_q <= (delay_q == '0) ? PVP_XFER : PVP_DELAY;
                    end
                end
                PVP_DELAY:
                begin
                    if (pe)
                    begin
                        dcnt_q <= dcnt_q - CW'(1);
                        if (dcnt_q == CW'(1))
                        begin
                            st_q <= PVP_XFER;
                        end
                    end
                end
                PVP_XFER:
                begin
                    if (pe)
                    begin
                        scnt_q <= scnt_q + CW'(1);
                        if (scnt_q + CW'(1) >= count_q)
                        begin
                            st_q <= PVP_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    // Video preamble tracking on the upper eight bits of a 10-bit sample, the low eight bits at other widths
    assign w8 = (wid == PVP_WID_10) ? din_s[9:2] : din_s[7:0];
    assign code = vid_rx && pe && pre_q == 2'h3;
    assign xy = w8;
    assign clr = code && sub != PVP_VID_ENT;
    assign win = (sub == PVP_VID_ENT) ? synced_q :
        (sub == PVP_VID_VBI) ? (synced_q && vb_q) : act_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !vid_rx)
        begin
            pre_q <= 2'h0;
        end
        else if (pe)
        begin
            if (w8 == PVP_PRE_HI)
            begin
                pre_q <= 2'h1;
            end
            else if (w8 == PVP_PRE_LO && (pre_q == 2'h1 || pre_q == 2'h2))
            begin
                pre_q <= pre_q + 2'h1;
            end
            else
            begin
                pre_q <= 2'h0;
            end
        end
    end

    // Field, blanking and active-line state from each decoded code
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !vid_rx)
        begin
            fld_q <= 1'b0;
            vb_q <= 1'b0;
            synced_q <= 1'b0;
            act_q <= 1'b0;
            lines_q <= '0;
        end
        else if (code)
        begin
            fld_q <= xy[PVP_XY_F];
            vb_q <= xy[PVP_XY_V];
            if (!xy[PVP_XY_F] && fld_q)
            begin
                synced_q <= 1'b1;
                lines_q <= count_q;
            end
            if (xy[PVP_XY_H] || xy[PVP_XY_V])
            begin
                act_q <= 1'b0;
            end
            else if (((!xy[PVP_XY_F] && fld_q) ? count_q : lines_q) != '0)
            begin
                act_q <= 1'b1;
                lines_q <= ((!xy[PVP_XY_F] && fld_q) ? count_q : lines_q) - CW'(1);
            end
        end
    end

    // Three-sample delay line lets a code retract its own preamble
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !vid_rx)
        begin
            dv_q <= 3'h0;
            for (int i = 0; i < 3; i++)
            begin
                dd_q[i] <= '0;
            end
        end
        else if (pe)
        begin
            dd_q[0] <= din_s & wmask;
            dd_q[1] <= dd_q[0];
            dd_q[2] <= dd_q[1];
            dv_q <= {dv_q[1] && !clr, dv_q[0] && !clr, win && !clr};
        end
    end

    // Receive path into the software holding register
    assign gp_take = pe && st_q == PVP_XFER && !fam && !gp_out;
    assign vid_take = vid_rx && pe && dv_q[2] && !clr;
    assign take = gp_take || vid_take;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rx_q <= '0;
            rxv_q <= 1'b0;
            ovf_q <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                rx_q <= gp_take ? (din_s & wmask) : dd_q[2];
            end
            // A new sample wins over a read in the same cycle
            rxv_q <= take || (rxv_q && !rd_data);
            ovf_q <= (take && rxv_q && !rd_data) ||
                (ovf_q && !(wr_status && hwdata_i[PVP_ST_OVF]));
        end
    end

    // Transmit path from the software holding register to the pins
    assign send = pe && ((st_q == PVP_XFER && gp_out) || vid_tx);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            tx_q <= '0;
            txf_q <= 1'b0;
            unf_q <= 1'b0;
            data_o <= '0;
        end
        else
        begin
            if (wr_q && addr_q == PVP_OFS_DATA)
            begin
                tx_q <= hwdata_i[DW-1:0];
            end
            if (send && txf_q)
            begin
                data_o <= tx_q & wmask;
            end
            // A write landing with a send keeps the word pending
            txf_q <= (wr_q && addr_q == PVP_OFS_DATA) || (txf_q && !send);
            unf_q <= (send && !txf_q) ||
                (unf_q && !(wr_status && hwdata_i[PVP_ST_UNF]));
        end
    end

endmodule // pvp_core

// File: core/pvp_pkg.sv
// Constants, types and helpers shared by the parallel video port.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.

package pvp_pkg;

    // Register byte offsets
    localparam logic [7:0] PVP_OFS_CTRL = 8'h00;
    localparam logic [7:0] PVP_OFS_STATUS = 8'h04;
    localparam logic [7:0] PVP_OFS_DELAY = 8'h08;
    localparam logic [7:0] PVP_OFS_COUNT = 8'h0c;
    localparam logic [7:0] PVP_OFS_LINE = 8'h10;
    localparam logic [7:0] PVP_OFS_FRAME = 8'h14;
    localparam logic [7:0] PVP_OFS_DATA = 8'h18;

    // Control field positions
    localparam int PVP_CTRL_EN = 0;
    localparam int PVP_CTRL_FAM = 1;
    localparam int PVP_CTRL_SUB = 2;
    localparam int PVP_CTRL_DIR = 4;
    localparam int PVP_CTRL_WID = 8;
    localparam int PVP_CTRL_FSO = 16;

    // Status bit positions
    localparam int PVP_ST_RXV = 0;
    localparam int PVP_ST_TXE = 1;
    localparam int PVP_ST_OVF = 2;
    localparam int PVP_ST_UNF = 3;
    localparam int PVP_ST_SYNC = 4;
    localparam int PVP_ST_BUSY = 5;
    localparam int PVP_ST_FIELD = 6;
    localparam int PVP_ST_VBL = 7;

    // Reset values
    localparam logic [31:0] PVP_CTRL_RST = 32'h0007_1000;
    localparam logic [15:0] PVP_DELAY_RST = 16'h0000;
    localparam logic [15:0] PVP_COUNT_RST = 16'h0000;
    localparam logic [15:0] PVP_LINE_RST = 16'h0010;
    localparam logic [15:0] PVP_FRAME_RST = 16'h0010;

    // Submode encodings
    localparam logic [1:0] PVP_SUB_IN = 2'h0;
    localparam logic [1:0] PVP_SUB_CAP = 2'h1;
    localparam logic [1:0] PVP_SUB_OUT = 2'h2;
    localparam logic [1:0] PVP_VID_ACT = 2'h0;
    localparam logic [1:0] PVP_VID_VBI = 2'h1;
    localparam logic [1:0] PVP_VID_ENT = 2'h2;

    // Sample widths and video preamble
    localparam logic [4:0] PVP_WID_8 = 5'h08;
    localparam logic [4:0] PVP_WID_10 = 5'h0a;
    localparam logic [4:0] PVP_WID_16 = 5'h10;
    localparam logic [7:0] PVP_PRE_HI = 8'hff;
    localparam logic [7:0] PVP_PRE_LO = 8'h00;
    localparam int PVP_XY_F = 6;
    localparam int PVP_XY_V = 5;
    localparam int PVP_XY_H = 4;

    typedef enum logic [1:0] {PVP_IDLE, PVP_WAIT, PVP_DELAY, PVP_XFER} pvp_state_t;

    // Mask of valid data bits; unsupported widths fall back to 16
    function automatic logic [15:0] pvp_wmask(input logic [4:0] w);
        logic [15:0] m;
        m = 16'hffff;
        if (w == PVP_WID_8)
        begin
            m = 16'h00ff;
        end
        else if (w >= PVP_WID_10 && w < PVP_WID_16)
        begin
            m = 16'hffff >> (5'h10 - w);
        end
        return m;
    endfunction

endpackage

// File: core/pvp_sync.sv
// Three-stage input synchroniser for pins from outside the clock domain.
// A bit changes at the output only once stages two and three agree.
`timescale 1ns/100ps
module pvp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] stable_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Stage one feeds stage two only
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per-bit agreement filter rejects single-stage glitches
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            stable_o <= '0;
        end
        else
        begin
            stable_o <= (s2_q & s3_q) | (stable_o & (s2_q | s3_q));
        end
    end

endmodule // pvp_sync

// File: testbench/pvp_core_sva.sv
// Checker for the parallel video port: bus timing and pin direction.
// Sees only pvp_core ports; bound from the testbench top file.
`timescale 1ns/100ps
module pvp_core_chk
    import pvp_pkg::*;
#(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Pins
    input wire logic port_clock_i,
    input wire logic [2:0] frame_sync_oe_o,
    input wire logic [DW-1:0] data_o,
    input wire logic data_oe_o
);
    logic take_w, take_r, rd_q, wr_q, pin_q1, pin_q2, dir_out;
    logic [7:0] adr_q;
    logic [31:0] ctrl_q;
    logic [2:0] out_q, fso_q;
    logic [3:0] cnt_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Accepted transfers and the direction the control word asks for
    assign take_w = hsel_i & htrans_i[1] & hready_i & hwrite_i;
    assign take_r = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
    assign dir_out = ctrl_q[PVP_CTRL_EN] & ((~ctrl_q[PVP_CTRL_FAM]
        & (ctrl_q[PVP_CTRL_SUB +: 2] == PVP_SUB_OUT)) | (ctrl_q[PVP_CTRL_FAM] & ctrl_q[PVP_CTRL_DIR]));
    // Data phase tracking; a new address phase may overlap the end of the old one
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= 8'h00;
        end
        else if (hready_i)
        begin
            rd_q <= take_r;
            wr_q <= take_w;
            adr_q <= haddr_i[7:0];
        end
    end
    // Shadow of the control word with a short history, since pins follow it late
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= PVP_CTRL_RST;
            out_q <= 3'h0;
            fso_q <= PVP_CTRL_RST[18:16];
        end
        else
        begin
            if (wr_q && hready_i && adr_q == PVP_OFS_CTRL)
                ctrl_q <= hwdata_i;
            out_q <= {out_q[1:0], dir_out};
            fso_q <= ctrl_q[18:16];
        end
    end
    // System clocks since the port clock pin last rose, saturating when it stands still
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_q1 <= 1'b0;
            pin_q2 <= 1'b0;
            cnt_q <= 4'hf;
        end
        else
        begin
            pin_q1 <= port_clock_i;
            pin_q2 <= pin_q1;
            cnt_q <= (pin_q1 & ~pin_q2) ? 4'h0 : ((cnt_q == 4'hf) ? 4'hf : cnt_q + 4'h1);
        end
    end
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("bus response not OKAY");
    a_read_wait: assert property (take_r |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state not exactly one cycle");
    a_write_nowait: assert property (take_w |=> hreadyout_o)
        else $error("write was stalled");
    a_wait_cause: assert property ($fell(hreadyout_o) |-> $past(take_r))
        else $error("wait state without a read");
    a_rdata_unmapped: assert property ((rd_q && hreadyout_o && adr_q > PVP_OFS_DATA)
        |-> hrdata_o == 32'h0) else $error("unmapped read not zero");
    a_rdata_narrow: assert property ((rd_q && hreadyout_o) |-> hrdata_o[31:19] == 13'h0)
        else $error("read data upper bits set");
    a_data_dir: assert property ((out_q == 3'h0 && !dir_out) |-> !data_oe_o)
        else $error("data driven outside output direction");
    a_fs_mask: assert property ((frame_sync_oe_o & ~ctrl_q[18:16] & ~fso_q) == 3'h0)
        else $error("frame sync driven without its enable");
    a_data_hold: assert property (($changed(data_o) && data_oe_o && $past(data_oe_o))
        |-> cnt_q inside {[2:7]}) else $error("data changed away from a port clock rise");
endmodule // pvp_core_chk

// File: testbench/pvp_far.sv
// Far-end model: parallel converter or video source and sink with its own port clock.
// The clock stands still between bursts; the bench calls play() for each burst.
`timescale 1ns/100ps
module pvp_far (
    // Lines from the port
    input wire logic [15:0] data_o_i,
    // Lines into the port
    output logic port_clock_o,
    output logic [2:0] fsync_o,
    output logic [15:0] pdata_o
);
    logic [15:0] seq [0:31];
    logic [2:0] fsq [0:31];
    logic [15:0] seen;
    // Idle levels before the first burst
    initial
    begin
        port_clock_o = 1'b0;
        fsync_o = 3'h0;
        pdata_o = 16'h5a5a;
        seen = 16'h0;
    end
    // 160 ns clock; syncs and data set up mid-low so they are steady across the rise
    task automatic play(input int n);
        #7;
        for (int i = 0; i < n; i++)
        begin
            #40 pdata_o = seq[i];
            fsync_o = fsq[i];
            #40 port_clock_o = 1'b1;
            seen = data_o_i;
            #80 port_clock_o = 1'b0;
            pdata_o = ~pdata_o; // Hold over: the old value must not linger
        end
    endtask
endmodule // pvp_far

// File: testbench/parallel_video_port_tb.sv
// Testbench for the parallel video port: bus, general-purpose and video modes.
// Expects pvp_core, pvp_far and pvp_core_chk compiled first.
`timescale 1ns/100ps
module parallel_video_port_tb;
    import pvp_pkg::*;
    logic clk_i, rst_n_i, hsel, hwrite, hready, hresp, doe, port_clock;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [2:0] fs_in, fs_out, fs_oe, fs_far, hsize;
    logic [15:0] din, dout, din_far, seed;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    int k, j, d, n, w;
    int wtab[8] = '{8, 10, 11, 12, 13, 14, 15, 16};
    logic [7:0] vs[20] = '{8'hff, 8'h00, 8'h00, 8'hf0, 8'h10, 8'hff, 8'h00, 8'h00, 8'h80,
        8'h11, 8'h22, 8'h33, 8'hff, 8'h00, 8'h00, 8'h90, 8'h10, 8'h10, 8'h10, 8'h10};
    // Wire levels: whoever enables drives
    assign fs_in = (fs_oe & fs_out) | (~fs_oe & fs_far);
    assign din = doe ? dout : din_far;
    pvp_core #(.DW(16), .CW(16)) pvp_core_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .port_clock_i(port_clock),
        .frame_sync_i(fs_in), .frame_sync_o(fs_out), .frame_sync_oe_o(fs_oe),
        .data_i(din), .data_o(dout), .data_oe_o(doe));
    pvp_far pvp_far_inst (.data_o_i(dout), .port_clock_o(port_clock), .fsync_o(fs_far),
        .pdata_o(din_far));
    // 50 MHz system clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Hang guard; the whole run needs well under this
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            complete_run();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] wmask(input int wd);
        return (wd == 8) ? 16'h00ff : 16'hffff >> (16 - wd);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single word transfer; waits on hready only, never on a cycle count
    task automatic ahb(input logic w_r, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdv);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        hwrite <= w_r;
        @(posedge clk_i);
        while (hready !== 1'b1)
            @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1)
            @(posedge clk_i);
        rdv = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ahb(1'b1, a, v, rd);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        seed = 16'h0019;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values and an unmapped word that must stay zero
        rchk(PVP_OFS_CTRL, PVP_CTRL_RST);
        rchk(PVP_OFS_LINE, {16'h0, PVP_LINE_RST});
        wr(8'h1c, 32'hffff_ffff);
        rchk(8'h1c, 32'h0);
        // Input submode: random delay, count and data, each width once, count zero first
        for (k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            d = seed[1:0];
            n = (k == 0) ? 0 : 1 + seed[4:2];
            for (j = 0; j < 32; j++)
            begin
                seed = lfsr(seed);
                pvp_far_inst.seq[j] = seed;
                pvp_far_inst.fsq[j] = (j < 2) ? 3'h1 : 3'h0;
            end
            wr(PVP_OFS_DELAY, 32'(d));
            wr(PVP_OFS_COUNT, 32'(n));
            wr(PVP_OFS_CTRL, 32'(wtab[k] << PVP_CTRL_WID) | 32'h1);
            pvp_far_inst.play(d + n + 4);
            repeat (12) @(posedge clk_i);
            ahb(1'b0, PVP_OFS_STATUS, 32'h0, rd);
            check(32'(rd[PVP_ST_RXV]), 32'(n != 0));
            check(32'(rd[PVP_ST_OVF]), 32'(n > 1));
            ahb(1'b0, PVP_OFS_DATA, 32'h0, rd);
            if (n != 0)
                check(rd, {16'h0, pvp_far_inst.seq[d + n] & wmask(wtab[k])});
            wr(PVP_OFS_STATUS, 32'hc);
            wr(PVP_OFS_CTRL, 32'h0);
        end
        // Frame capture: syncs driven by the port, data lines left to the source
        wr(PVP_OFS_DELAY, 32'h0);
        wr(PVP_OFS_COUNT, 32'h1);
        wr(PVP_OFS_CTRL, 32'h0007_1005);
        pvp_far_inst.play(4);
        check(32'(fs_oe[1:0]), 32'h3);
        check(32'(doe), 32'h0);
        // Output submode: one word each at widths 8 and 16, taken by the far end on its clock
        for (k = 0; k < 2; k++)
        begin
            seed = lfsr(seed);
            w = (k == 0) ? 8 : 16;
            wr(PVP_OFS_CTRL, 32'h0);
            wr(PVP_OFS_CTRL, 32'h0007_0009 | 32'(w << PVP_CTRL_WID));
            wr(PVP_OFS_DATA, {16'h0, seed});
            pvp_far_inst.play(4);
            check(32'(doe), 32'h1);
            check({16'h0, pvp_far_inst.seen}, {16'h0, seed & wmask(w)});
        end
        // Video receive: one stream through active, blanking and entire submodes
        for (k = 0; k < 3; k++)
        begin
            for (j = 0; j < 20; j++)
            begin
                pvp_far_inst.seq[j] = {8'h0, vs[j]};
                pvp_far_inst.fsq[j] = 3'h0;
            end
            wr(PVP_OFS_COUNT, 32'h4);
            wr(PVP_OFS_CTRL, 32'h0000_0803 | 32'(k << PVP_CTRL_SUB));
            pvp_far_inst.play(20);
            repeat (12) @(posedge clk_i);
            ahb(1'b0, PVP_OFS_STATUS, 32'h0, rd);
            check(32'(rd[PVP_ST_SYNC]), 32'h1);
            check(32'(rd[PVP_ST_RXV]), 32'(k != 1));
            ahb(1'b0, PVP_OFS_DATA, 32'h0, rd);
            if (k != 1)
                check(rd, (k == 0) ? 32'h33 : 32'h10);
            wr(PVP_OFS_STATUS, 32'hc);
            wr(PVP_OFS_CTRL, 32'h0);
        end
        complete_run();
    end
endmodule // parallel_video_port_tb
bind pvp_core pvp_core_chk #(.DW(DW)) pvp_core_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .port_clock_i(port_clock_i),
    .frame_sync_oe_o(frame_sync_oe_o), .data_o(data_o), .data_oe_o(data_oe_o));
